// >>> design/slc_pkg.sv
// Shared constants, field layouts and state types for the link register set
package slc_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_LINKS = 8; // Links per register group
  localparam int IDX_W = 3; // Link index width
  localparam int GAP_W = 11; // Spacing field width
  localparam int GAP_CNT_W = 12; // Spacing counter width, holds gap plus one
  localparam int CHAN_W = 5; // Channel end number width
  localparam int NET_W = 2; // Network field width
  localparam int DIR_W = 4; // Direction field width
  localparam int DEST_W = 8; // Destination link width
  localparam int TYPE_W = 2; // Source target type width
  ////////////////////////////////////////////////////////////////////////////
  // Register group base addresses
  localparam logic [7:0] SL_STATUS_BASE = 8'h20; // Switch-side link status
  localparam logic [7:0] PL_STATUS_BASE = 8'h40; // Processor-side link status
  localparam logic [7:0] LINK_CFG_BASE = 8'h80; // External link configuration
  localparam logic [7:0] STATIC_CFG_BASE = 8'ha0; // Static forwarding
  ////////////////////////////////////////////////////////////////////////////
  // Status field positions
  localparam int BUSY_SRC_BIT = 0; // Source side occupied
  localparam int BUSY_DST_BIT = 1; // Destination side occupied
  localparam int JUNK_BIT = 2; // Packet being discarded
  localparam int NET_LSB = 4; // Network number
  localparam int DIR_LSB = 8; // Routing direction
  localparam int DEST_LSB = 16; // Destination link
  localparam int TYPE_LSB = 24; // Source target type
  // Link configuration field positions
  localparam int LINK_EN_BIT = 31; // Link enable
  localparam int WIDE_BIT = 30; // Five-wire mode
  localparam int RX_ERR_BIT = 27; // Overflow or illegal token
  localparam int CRED_ISSUED_BIT = 26; // Credit granted to far end
  localparam int CRED_HELD_BIT = 25; // Credit held locally
  localparam int CRED_REQ_BIT = 24; // Credit request strobe
  localparam int RX_RESET_BIT = 23; // Receiver reset strobe
  localparam int SYM_GAP_LSB = 11; // Idle clocks between symbols
  localparam int TOK_GAP_LSB = 0; // Idle clocks between tokens
  // Static forwarding field positions
  localparam int STATIC_EN_BIT = 31; // Static forwarding enable
  localparam int CHAN_LSB = 0; // Destination channel end
  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [NET_W-1:0] NET_RST = 2'h0;
  localparam logic [DIR_W-1:0] DIR_RST = 4'h0;
  localparam logic [GAP_W-1:0] GAP_RST = 11'h000;
  localparam logic [CHAN_W-1:0] CHAN_RST = 5'h00;
  localparam logic [GAP_CNT_W-1:0] CNT_ONE = 12'h001; // Gap offset and step
  // Static register index to link letter number (A=0 .. H=7)
  localparam logic [IDX_W-1:0] STATIC_LINK_MAP [NUM_LINKS] =
    '{3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7, 3'h4, 3'h5};
  // Source target type encodings
  typedef enum logic [TYPE_W-1:0] {
    SRC_SWITCH_LINK = 2'h0, SRC_PROC_LINK = 2'h1,
    SRC_SWITCH_CTRL = 2'h2, SRC_UNDEFINED = 2'h3
  } slc_src_type_t;
  // Register state of the main block
  typedef struct packed {
    logic [NUM_LINKS-1:0][NET_W-1:0] slNet; // Switch link network
    logic [NUM_LINKS-1:0][DIR_W-1:0] slDir; // Switch link direction
    logic [NUM_LINKS-1:0][NET_W-1:0] plNet; // Processor link network
    logic [NUM_LINKS-1:0] en; // Link enables
    logic [NUM_LINKS-1:0] wide; // Five-wire modes
    logic [NUM_LINKS-1:0][GAP_W-1:0] symGap; // Symbol spacing
    logic [NUM_LINKS-1:0][GAP_W-1:0] tokGap; // Token spacing
    logic [NUM_LINKS-1:0] stEn; // Static enable, by link letter
    logic [NUM_LINKS-1:0][CHAN_W-1:0] stChan; // Static channel, by letter
    logic [NUM_LINKS-1:0] credReq; // Credit request pulses
    logic [NUM_LINKS-1:0] rxRst; // Receiver reset pulses
    logic [31:0] rdData; // Read answer
    logic rdValid; // Read answer strobe
  } slc_regs_t;
  // Pacer state
  typedef struct packed {
    logic [GAP_CNT_W-1:0] count; // Idle clocks still owed
    logic ready; // Next symbol may go
  } slc_pacer_t;
  // Address falls in an eight-register group
  function automatic logic slc_in_group(input logic [7:0] addr,
                                        input logic [7:0] base);
    return addr[7:IDX_W] == base[7:IDX_W];
  endfunction
endpackage

// >>> design/slc_tx_pacer.sv
// Transmit spacing pacer for one external link
module slc_tx_pacer (
  input wire logic ref_clk, // System switch clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic enable, // Link enabled
  input wire logic txSymbol, // Symbol sent this cycle
  input wire logic txTokenEnd, // That symbol ends a token
  input wire logic [slc_pkg::GAP_W-1:0] symGap, // Symbol spacing minus one
  input wire logic [slc_pkg::GAP_W-1:0] tokGap, // Token spacing minus one
  output logic txReady // Next symbol may be sent
);
  import slc_pkg::*;

  slc_pacer_t r_reg; // Registered state
  slc_pacer_t r_next; // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Next state: load the owed idle count, then count it down
  always_comb begin
    r_next = r_reg;
    if (!enable) begin
      // Disabled link sends nothing
      r_next.count = '0;
    end else if (txSymbol && !txTokenEnd) begin
      r_next.count = {1'b0, symGap} + CNT_ONE;
    end else if (txSymbol) begin
      r_next.count = {1'b0, tokGap} + CNT_ONE;
    end else if (r_reg.count != '0) begin
      r_next.count = r_reg.count - CNT_ONE;
    end
    r_next.ready = enable && (r_next.count == '0);
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign txReady = r_reg.ready;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_sym_space;
    txSymbol && !txTokenEnd && enable && symGap == '0 |=>
      !txReady ##1 (txReady || !enable || txSymbol);
  endproperty
  a_sym_space: assert property (p_sym_space) else $error("symbol gap wrong");

  property p_tok_space;
    txSymbol && txTokenEnd && enable && tokGap == 11'h001 |=>
      !txReady [*2] ##1 (txReady || !enable || txSymbol);
  endproperty
  a_tok_space: assert property (p_tok_space) else $error("token gap wrong");
endmodule

// >>> design/slc_link_regs.sv
// Link control and status register set of the packet switch
//
// How it works
// - bit 2 shows junk packet discard
// - bits 1,0 show dest/source busy
// - bits 25:24 give source target type
// - bits 23:16 give destination link number
// - bits 5:4 writable network, reset zero
// - bit 31 enables link, steers pins
// - bit 30 picks two or five wires
// - bit 27 shows overflow or bad token
// - bit 26 shows credit granted remotely
// - bit 25 shows credit held locally
// - bit 24 write requests fresh credit
// - bit 23 write resets the receiver
// - symbol gap field plus one idles
// - token gap field plus one idles
// - static bit forwards all to channel
// - bits 4:0 name static channel end
// - static registers map C,D,A,B,G,H,E,F
// - config group at 0x80 covers links 0-7
// - bits 11:8 writable direction, reset zero
module slc_link_regs (
  input wire logic ref_clk, // System switch clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic cfgWrite, // Configuration write strobe
  input wire logic cfgRead, // Configuration read strobe
  input wire logic [7:0] cfgAddr, // Register number
  input wire logic [31:0] cfgWrData, // Write data
  output logic [31:0] cfgRdData, // Read data, one cycle after read
  output logic cfgRdValid, // Read data valid pulse
  input wire logic [slc_pkg::NUM_LINKS-1:0] slBusySrc, // Switch link source busy
  input wire logic [slc_pkg::NUM_LINKS-1:0] slBusyDst, // Switch link dest busy
  input wire logic [slc_pkg::NUM_LINKS-1:0] slJunk, // Switch link junk packet
  input wire logic [slc_pkg::NUM_LINKS-1:0][slc_pkg::DEST_W-1:0] slDest, // Dest link
  input wire logic [slc_pkg::NUM_LINKS-1:0][slc_pkg::TYPE_W-1:0] slType, // Source type
  input wire logic [slc_pkg::NUM_LINKS-1:0] plBusySrc, // Proc link source busy
  input wire logic [slc_pkg::NUM_LINKS-1:0] plBusyDst, // Proc link dest busy
  input wire logic [slc_pkg::NUM_LINKS-1:0] plJunk, // Proc link junk packet
  input wire logic [slc_pkg::NUM_LINKS-1:0][slc_pkg::DEST_W-1:0] plDest, // Dest link
  input wire logic [slc_pkg::NUM_LINKS-1:0][slc_pkg::TYPE_W-1:0] plType, // Source type
  input wire logic [slc_pkg::NUM_LINKS-1:0] rxError, // Overflow or bad token
  input wire logic [slc_pkg::NUM_LINKS-1:0] creditIssued, // Credit granted remotely
  input wire logic [slc_pkg::NUM_LINKS-1:0] creditHeld, // Credit held locally
  input wire logic [slc_pkg::NUM_LINKS-1:0] txSymbol, // Symbol sent now
  input wire logic [slc_pkg::NUM_LINKS-1:0] txTokenEnd, // Symbol ends token
  output logic [slc_pkg::NUM_LINKS-1:0] linkTxReady, // Spacing met
  output logic [slc_pkg::NUM_LINKS-1:0] linkEnable, // Link on, pin mux select
  output logic [slc_pkg::NUM_LINKS-1:0] linkWide, // Five-wire mode
  output logic [slc_pkg::NUM_LINKS-1:0] creditRequest, // Clear credit, send request
  output logic [slc_pkg::NUM_LINKS-1:0] rxReset, // Receiver reset pulse
  output logic [slc_pkg::NUM_LINKS-1:0][slc_pkg::NET_W-1:0] slNetwork, // Network
  output logic [slc_pkg::NUM_LINKS-1:0][slc_pkg::DIR_W-1:0] slDirection, // Direction
  output logic [slc_pkg::NUM_LINKS-1:0][slc_pkg::NET_W-1:0] plNetwork, // Network
  output logic [slc_pkg::NUM_LINKS-1:0] staticEnable, // Static mode, by link A..H
  output logic [slc_pkg::NUM_LINKS-1:0][slc_pkg::CHAN_W-1:0] staticChan // Channel
);
  import slc_pkg::*;

  // One write and one read strobe reach every field.
  // Reads answer one cycle later. Status bits are
  // live levels, as are the error and credit bits; all other fields are stored here.

  // State register and its next value
  slc_regs_t r_reg; // Registered state
  slc_regs_t r_next; // Next state

  // Address decode helpers
  logic [IDX_W-1:0] cfgIdx; // Link index within a group
  logic [IDX_W-1:0] stLink; // Link letter of a static register

  // Low bits pick the link
  assign cfgIdx = cfgAddr[IDX_W-1:0];

  // static register order
  // Register index to link letter
  assign stLink = STATIC_LINK_MAP[cfgIdx];

  ////////////////////////////////////////////////////////////////////////////
  // Next state: writes, strobes and read answers
  always_comb begin
    // Hold every stored field
    r_next = r_reg;

    // Strobes last one cycle
    r_next.credReq = '0;
    r_next.rxRst = '0;

    // Answer follows each read
    r_next.rdValid = cfgRead;
    r_next.rdData = '0;

    // Writes; read-only and reserved bits are not stored
    if (cfgWrite) begin
      // Switch link status
      if (slc_in_group(cfgAddr, SL_STATUS_BASE)) begin
        r_next.slNet[cfgIdx] = cfgWrData[NET_LSB +: NET_W];

        r_next.slDir[cfgIdx] = cfgWrData[DIR_LSB +: DIR_W];

      // Processor link status
      end else if (slc_in_group(cfgAddr, PL_STATUS_BASE)) begin
        r_next.plNet[cfgIdx] = cfgWrData[NET_LSB +: NET_W];

      end else if (slc_in_group(cfgAddr, LINK_CFG_BASE)) begin
        r_next.en[cfgIdx] = cfgWrData[LINK_EN_BIT];

        r_next.wide[cfgIdx] = cfgWrData[WIDE_BIT];

        r_next.credReq[cfgIdx] = cfgWrData[CRED_REQ_BIT];

        r_next.rxRst[cfgIdx] = cfgWrData[RX_RESET_BIT];

        r_next.symGap[cfgIdx] = cfgWrData[SYM_GAP_LSB +: GAP_W];

        r_next.tokGap[cfgIdx] = cfgWrData[TOK_GAP_LSB +: GAP_W];

      // Static forwarding, by letter
      end else if (slc_in_group(cfgAddr, STATIC_CFG_BASE)) begin
        r_next.stEn[stLink] = cfgWrData[STATIC_EN_BIT];

        r_next.stChan[stLink] = cfgWrData[CHAN_LSB +: CHAN_W];
      end
      // Unmapped numbers: write dropped
    end

    // Read answers; unmapped numbers answer zero
    if (cfgRead) begin
      // Switch link status
      if (slc_in_group(cfgAddr, SL_STATUS_BASE)) begin
        r_next.rdData[JUNK_BIT] = slJunk[cfgIdx];

        r_next.rdData[BUSY_DST_BIT] = slBusyDst[cfgIdx];
        r_next.rdData[BUSY_SRC_BIT] = slBusySrc[cfgIdx];

        r_next.rdData[TYPE_LSB +: TYPE_W] = slType[cfgIdx];

        r_next.rdData[DEST_LSB +: DEST_W] = slDest[cfgIdx];

        r_next.rdData[NET_LSB +: NET_W] = r_reg.slNet[cfgIdx];

        r_next.rdData[DIR_LSB +: DIR_W] = r_reg.slDir[cfgIdx];

      // Processor link status, no direction
      end else if (slc_in_group(cfgAddr, PL_STATUS_BASE)) begin
        r_next.rdData[JUNK_BIT] = plJunk[cfgIdx];

        r_next.rdData[BUSY_DST_BIT] = plBusyDst[cfgIdx];
        r_next.rdData[BUSY_SRC_BIT] = plBusySrc[cfgIdx];

        r_next.rdData[TYPE_LSB +: TYPE_W] = plType[cfgIdx];

        r_next.rdData[DEST_LSB +: DEST_W] = plDest[cfgIdx];

        r_next.rdData[NET_LSB +: NET_W] = r_reg.plNet[cfgIdx];

      // Link configuration
      end else if (slc_in_group(cfgAddr, LINK_CFG_BASE)) begin
        r_next.rdData[LINK_EN_BIT] = r_reg.en[cfgIdx];

        r_next.rdData[WIDE_BIT] = r_reg.wide[cfgIdx];

        r_next.rdData[RX_ERR_BIT] = rxError[cfgIdx];

        r_next.rdData[CRED_ISSUED_BIT] = creditIssued[cfgIdx];

        r_next.rdData[CRED_HELD_BIT] = creditHeld[cfgIdx];

        r_next.rdData[SYM_GAP_LSB +: GAP_W] = r_reg.symGap[cfgIdx];
        r_next.rdData[TOK_GAP_LSB +: GAP_W] = r_reg.tokGap[cfgIdx];

      // Static forwarding, by letter
      end else if (slc_in_group(cfgAddr, STATIC_CFG_BASE)) begin
        r_next.rdData[STATIC_EN_BIT] = r_reg.stEn[stLink];

        r_next.rdData[CHAN_LSB +: CHAN_W] = r_reg.stChan[stLink];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with reset values
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      // Strobes, enables and answers clear
      r_reg <= '0;

      // Writable fields take reset values
      r_reg.slNet <= {NUM_LINKS{NET_RST}};
      r_reg.slDir <= {NUM_LINKS{DIR_RST}};
      r_reg.plNet <= {NUM_LINKS{NET_RST}};

      // Spacing fields
      r_reg.symGap <= {NUM_LINKS{GAP_RST}};
      r_reg.tokGap <= {NUM_LINKS{GAP_RST}};

      // Static channel ends
      r_reg.stChan <= {NUM_LINKS{CHAN_RST}};
    end else begin
      // Take the next state
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  // Read port
  assign cfgRdData = r_reg.rdData;
  assign cfgRdValid = r_reg.rdValid;

  // Per-link controls
  assign linkEnable = r_reg.en;
  assign linkWide = r_reg.wide;

  // One-cycle strobes
  assign creditRequest = r_reg.credReq;
  assign rxReset = r_reg.rxRst;

  // Routing fields
  assign slNetwork = r_reg.slNet;
  assign slDirection = r_reg.slDir;
  assign plNetwork = r_reg.plNet;

  // Static forwarding, by letter
  assign staticEnable = r_reg.stEn;
  assign staticChan = r_reg.stChan;

  ////////////////////////////////////////////////////////////////////////////
  // One spacing pacer per external link
  // Each pacer takes its gaps live
  // from the stored fields
  for (genvar i = 0; i < NUM_LINKS; i++) begin : g_pacer
    slc_tx_pacer u_pacer (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .enable(r_reg.en[i]),
      .txSymbol(txSymbol[i]),
      .txTokenEnd(txTokenEnd[i]),
      .symGap(r_reg.symGap[i]),
      .tokGap(r_reg.tokGap[i]),
      .txReady(linkTxReady[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // One clock, reset disables
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Check helper
  logic cfgWin; // Write to configuration group
  assign cfgWin = cfgWrite && slc_in_group(cfgAddr, LINK_CFG_BASE);

  // Enable stored as written
  property p_link_en;
    cfgWin |=> linkEnable[$past(cfgIdx)] == $past(cfgWrData[LINK_EN_BIT]);
  endproperty
  a_link_en: assert property (p_link_en) else $error("enable not stored");

  // Width stored as written
  property p_wide;
    cfgWin |=> linkWide[$past(cfgIdx)] == $past(cfgWrData[WIDE_BIT]);
  endproperty
  a_wide: assert property (p_wide) else $error("width not stored");

  // Request is a lone pulse
  property p_cred_req;
    cfgWin && cfgWrData[CRED_REQ_BIT] |=> creditRequest[$past(cfgIdx)]
      ##1 (creditRequest == '0 || $past(cfgWrite));
  endproperty
  a_cred_req: assert property (p_cred_req) else $error("credit request lost");

  // Restart pulse follows write
  property p_rx_rst;
    cfgWin && cfgWrData[RX_RESET_BIT] |=> rxReset[$past(cfgIdx)];
  endproperty
  a_rx_rst: assert property (p_rx_rst) else $error("rx reset lost");

  // Network and direction stored
  property p_sl_net;
    cfgWrite && slc_in_group(cfgAddr, SL_STATUS_BASE) |=>
      slNetwork[$past(cfgIdx)] == $past(cfgWrData[NET_LSB +: NET_W]) &&
      slDirection[$past(cfgIdx)] == $past(cfgWrData[DIR_LSB +: DIR_W]);
  endproperty
  a_sl_net: assert property (p_sl_net) else $error("network not stored");

  // Static bit lands on its letter
  property p_static;
    cfgWrite && slc_in_group(cfgAddr, STATIC_CFG_BASE) |=>
      staticEnable[$past(stLink)] == $past(cfgWrData[STATIC_EN_BIT]);
  endproperty
  a_static: assert property (p_static) else $error("static map wrong");

  // Strobe bits read zero
  property p_wo_zero;
    cfgRead && slc_in_group(cfgAddr, LINK_CFG_BASE) |=> cfgRdValid &&
      cfgRdData[CRED_REQ_BIT] == 1'b0 && cfgRdData[RX_RESET_BIT] == 1'b0;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("strobe bit read");

  // No answer without a read
  property p_rd_once;
    !cfgRead |=> !cfgRdValid && cfgRdData == '0;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("stray read answer");

  // Main scenarios
  c_enable: cover property (cfgWin && cfgWrData[LINK_EN_BIT]);
  c_static: cover property (cfgWrite && slc_in_group(cfgAddr, STATIC_CFG_BASE));
  c_junk: cover property (cfgRead && slJunk[cfgIdx] ##1 cfgRdValid);
endmodule

// >>> verification/slc_far_link.sv
// Far-end link model: credit exchange, receive errors and a token source
module slc_far_link #(
  parameter int CRED_DLY = 4 // Cycles before the far end returns credit
) (
  input wire logic ref_clk, // System switch clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [slc_pkg::NUM_LINKS-1:0] linkEnable, // Link on
  input wire logic [slc_pkg::NUM_LINKS-1:0] linkTxReady, // Spacing met
  input wire logic [slc_pkg::NUM_LINKS-1:0] creditRequest, // Credit request pulse
  input wire logic [slc_pkg::NUM_LINKS-1:0] rxReset, // Receiver restart pulse
  input wire logic [slc_pkg::NUM_LINKS-1:0] sendEn, // Bench asks for tokens
  input wire logic [slc_pkg::NUM_LINKS-1:0] injectErr, // Bench forces a bad token
  output logic [slc_pkg::NUM_LINKS-1:0] rxError, // Overflow or bad token
  output logic [slc_pkg::NUM_LINKS-1:0] creditIssued, // Credit granted to far end
  output logic [slc_pkg::NUM_LINKS-1:0] creditHeld, // Credit held locally
  output logic [slc_pkg::NUM_LINKS-1:0] txSymbol, // Symbol sent this cycle
  output logic [slc_pkg::NUM_LINKS-1:0] txTokenEnd // Symbol closes a token
);
  timeunit 1ns;
  timeprecision 1ns;
  import slc_pkg::*;
  logic [NUM_LINKS-1:0] phase; // Next symbol closes a token
  logic [NUM_LINKS-1:0][3:0] waitCnt; // Cycles until credit returns
  logic go; // Symbol goes out now
  ////////////////////////////////////////////////////////////////////////////
  // Per-link behaviour, all moves just after the rising edge
  always @(posedge ref_clk) begin
    for (int i = 0; i < NUM_LINKS; i++) begin
      if (!reset_n) begin
        {rxError[i], creditIssued[i], creditHeld[i], txSymbol[i]} <= 4'h0;
        {txTokenEnd[i], phase[i]} <= 2'h0;
        waitCnt[i] <= 4'h0;
      end else begin
        creditIssued[i] <= linkEnable[i];
        if (creditRequest[i] || (linkEnable[i] && !creditIssued[i])) begin
          creditHeld[i] <= 1'b0;
          waitCnt[i] <= 4'(CRED_DLY);
        end else if (waitCnt[i] != 4'h0) begin
          waitCnt[i] <= waitCnt[i] - 4'h1;
          creditHeld[i] <= (waitCnt[i] == 4'h1);
        end
        if (rxReset[i]) begin
          rxError[i] <= 1'b0;
        end else if (injectErr[i]) begin
          rxError[i] <= 1'b1;
        end
        go = sendEn[i] && linkEnable[i] && linkTxReady[i] && !txSymbol[i];
        txSymbol[i] <= go;
        txTokenEnd[i] <= go && phase[i];
        if (go) begin
          phase[i] <= !phase[i];
        end
      end
    end
  end
endmodule

// >>> verification/tb.sv
// Self-checking bench for the link register set
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import slc_pkg::*;
  logic ref_clk = 1'b0; // System clock
  logic reset_n, cfgWrite, cfgRead, cfgRdValid; // Control and answer strobes
  logic [7:0] cfgAddr; // Register number
  logic [31:0] cfgWrData, cfgRdData; // Data paths
  logic [7:0] slBusySrc, slBusyDst, slJunk, plBusySrc, plBusyDst, plJunk; // Status
  logic [7:0][7:0] slDest, plDest; // Destination links
  logic [7:0][1:0] slType, plType, slNetwork, plNetwork; // Types and networks
  logic [7:0][3:0] slDirection; // Directions
  logic [7:0][4:0] staticChan; // Static channels
  logic [7:0] rxError, creditIssued, creditHeld, txSymbol, txTokenEnd; // Far end
  logic [7:0] linkTxReady, linkEnable, linkWide, creditRequest, rxReset; // Controls
  logic [7:0] staticEnable, sendEn, injectErr; // Static enables, bench requests
  logic [7:0] bases [4] = '{8'h20, 8'h40, 8'h80, 8'ha0}; // Group bases
  int errorCnt = 0; // Mismatches
  int samplesChecked = 0; // Comparisons
  ////////////////////////////////////////////////////////////////////////////
  // Clock, device and far end
  always #50 ref_clk = ~ref_clk;
  slc_link_regs slc_link_regs_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .slBusySrc(slBusySrc),
    .slBusyDst(slBusyDst), .slJunk(slJunk), .slDest(slDest), .slType(slType),
    .plBusySrc(plBusySrc), .plBusyDst(plBusyDst), .plJunk(plJunk), .plDest(plDest),
    .plType(plType), .rxError(rxError), .creditIssued(creditIssued),
    .creditHeld(creditHeld), .txSymbol(txSymbol), .txTokenEnd(txTokenEnd),
    .linkTxReady(linkTxReady), .linkEnable(linkEnable), .linkWide(linkWide),
    .creditRequest(creditRequest), .rxReset(rxReset), .slNetwork(slNetwork),
    .slDirection(slDirection), .plNetwork(plNetwork), .staticEnable(staticEnable),
    .staticChan(staticChan));
  slc_far_link slc_far_link_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .linkEnable(linkEnable), .linkTxReady(linkTxReady), .creditRequest(creditRequest),
    .rxReset(rxReset), .sendEn(sendEn), .injectErr(injectErr), .rxError(rxError),
    .creditIssued(creditIssued), .creditHeld(creditHeld), .txSymbol(txSymbol),
    .txTokenEnd(txTokenEnd));
  ////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and bus cycles
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stopTest();
    $display("errors %0d, comparisons %0d", errorCnt, samplesChecked);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Read one word, answer lands one cycle later
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge ref_clk);
    cfgAddr = a;
    cfgRead = 1'b1;
    @(negedge ref_clk);
    cfgRead = 1'b0;
    check({31'h0, cfgRdValid}, 32'h1);
    check(cfgRdData, e);
  endtask
  // Write one word; returns in the cycle the fields change
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    cfgAddr = a;
    cfgWrData = d;
    cfgWrite = 1'b1;
    @(negedge ref_clk);
    cfgWrite = 1'b0;
  endtask
  // Time symbol spacing on one link over two tokens
  task automatic pace(input int k, input int sg, input int tg);
    int c;
    @(negedge ref_clk);
    sendEn[k] = 1'b1;
    c = 0;
    do begin @(posedge ref_clk); c++; end while (txSymbol[k] !== 1'b1 && c < 50);
    for (int n = 0; n < 4; n++) begin
      c = 0;
      do begin @(posedge ref_clk); c++; end while (txSymbol[k] !== 1'b1 && c < 3000);
      check(32'(c), 32'(((n % 2) ? tg : sg) + 3));
    end
    @(negedge ref_clk);
    sendEn[k] = 1'b0;
  endtask
  // Config word written, with ones in reserved and read-only places
  function automatic logic [31:0] cfgW(input int i);
    return {1'b1, i[0], 2'b11, 3'b111, 2'b00, 1'b1, 11'(i * 5), 11'(2047 - i)};
  endfunction
  // Config word expected back with credit held and issued
  function automatic logic [31:0] cfgE(input int i);
    return {1'b1, i[0], 3'b000, 2'b11, 3'b000, 11'(i * 5), 11'(2047 - i)};
  endfunction
  // Status word expected from the bench's own levels
  function automatic logic [31:0] stE(input int i, input logic pl);
    return pl ? {6'h0, plType[i], plDest[i], 8'h0, 2'h0, 2'(i), 1'b0, plJunk[i],
                 plBusyDst[i], plBusySrc[i]}
              : {6'h0, slType[i], slDest[i], 4'h0, 4'(15 - i), 2'h0, 2'(i), 1'b0,
                 slJunk[i], slBusyDst[i], slBusySrc[i]};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, well beyond the longest spacing run
  initial begin
    repeat (20000) @(posedge ref_clk);
    errorCnt++;
    stopTest();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    {reset_n, cfgWrite, cfgRead, cfgAddr, cfgWrData} = '0;
    {slBusySrc, slBusyDst, slJunk, plBusySrc, plBusyDst, plJunk} = '0;
    {slDest, plDest, slType, plType, sendEn, injectErr} = '0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    // Reset values, plus the hole just past each group
    for (int b = 0; b < 4; b++) begin
      for (int i = 0; i < 9; i++) rd(bases[b] + 8'(i), 32'h0);
    end
    // Live status levels, every source type code
    for (int i = 0; i < 8; i++) begin
      {slBusySrc[i], slBusyDst[i], slJunk[i]} = {i[0], i[1], i[2]};
      {plBusySrc[i], plBusyDst[i], plJunk[i]} = ~{i[0], i[1], i[2]};
      {slDest[i], plDest[i], slType[i], plType[i]} = {8'(16 + i), 8'(200 + i), 2'(i), 2'(3 - i)};
    end
    for (int i = 0; i < 8; i++) begin
      wr(8'h20 + 8'(i), 32'hfffff0cf | (32'(15 - i) << 8) | (32'(i % 4) << 4));
      wr(8'h40 + 8'(i), 32'hffffffcf | (32'(i % 4) << 4));
      rd(8'h20 + 8'(i), stE(i, 1'b0));
      rd(8'h40 + 8'(i), stE(i, 1'b1));
      check({slDirection[i], slNetwork[i], plNetwork[i]}, {24'h0, 4'(15 - i), 2'(i), 2'(i)});
    end
    // Link configuration over all eight links
    for (int i = 0; i < 8; i++) wr(8'h80 + 8'(i), cfgW(i));
    check({linkEnable, linkWide}, 32'hffaa);
    repeat (8) @(negedge ref_clk);
    for (int i = 0; i < 8; i++) rd(8'h80 + 8'(i), cfgE(i));
    // Credit request on link 3 only
    wr(8'h83, 32'h81000000);
    check({creditRequest, rxReset}, 32'h0800);
    rd(8'h83, 32'h84000000);
    repeat (8) @(negedge ref_clk);
    rd(8'h83, 32'h86000000);
    // Receive error on link 5, then receiver restart
    @(negedge ref_clk);
    injectErr = 8'h20;
    @(negedge ref_clk);
    injectErr = 8'h00;
    rd(8'h85, cfgE(5) | 32'h08000000);
    wr(8'h85, cfgW(5) | 32'h00800000);
    check({creditRequest, rxReset}, 32'h0020);
    rd(8'h85, cfgE(5));
    // Spacing: short gaps, then widest token gap
    wr(8'h81, 32'h80000001);
    pace(1, 0, 1);
    wr(8'h86, 32'h80001fff);
    pace(6, 3, 2047);
    // Disable one link
    wr(8'h82, 32'h00000000);
    check({24'h0, linkEnable}, 32'hfb);
    // Static forwarding, register order C D A B G H E F
    for (int k = 0; k < 8; k++) begin
      wr(8'ha0 + 8'(k), {k[0], 26'h3ffffff, 5'(k * 3 + 1)});
      rd(8'ha0 + 8'(k), {k[0], 26'h0, 5'(k * 3 + 1)});
      check({staticEnable[k ^ 2], 26'h0, staticChan[k ^ 2]}, {k[0], 26'h0, 5'(k * 3 + 1)});
    end
    stopTest();
  end
endmodule
